// ### bench/word_table_queue_search_engine_test.sv
// Purpose: Self-checking bench for the table remove and search engine
// Assumes: Memory model answers one cycle after each read strobe
// Notes:   Rows run in order on one table at 16'h0040
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module word_table_queue_search_engine_test;
   import wtq_pkg::*;
   typedef struct {logic [1:0] op; logic [2:0] c; logic [15:0] p, i, v, n; logic f;} wtq_row_t;
   logic              ref_clk = 1'b0, nrst = 1'b0, op_start = 1'b0;
   logic [1:0]        op_code = 2'h0;
   logic [2:0]        compare_code = 3'h0;
   logic [WTQ_AW-1:0] table_base = 16'h0000, mem_addr;
   logic [WTQ_DW-1:0] search_pattern = 16'h0000, search_index_in = 16'h0000, mem_wdata, mem_rdata;
   logic [WTQ_DW-1:0] data_out, search_index;
   logic              mem_rd, mem_wr, busy, op_done, data_out_we, search_index_we, empty_table_flag;
   int                n_mismatch = 0, comparisons = 0, cyc = 0;
   // Operation, code, pattern, start index, result, count word, empty flag
   wtq_row_t rows [12] = '{
      '{2'h3, 3'h1, 16'h0942, 16'h0, 16'h1, 16'h3, 1'h0}, '{2'h3, 3'h2, 16'h0531, 16'h0, 16'h1, 16'h3, 1'h0},
      '{2'h3, 3'h3, 16'h0300, 16'h0, 16'h2, 16'h3, 1'h0}, '{2'h3, 3'h4, 16'h0600, 16'h0, 16'h1, 16'h3, 1'h0},
      '{2'h3, 3'h1, 16'h0942, 16'h2, 16'h3, 16'h3, 1'h0}, '{2'h3, 3'h1, 16'h0531, 16'h3, 16'h3, 16'h3, 1'h0},
      '{2'h1, 3'h0, 16'h0, 16'h0, 16'h0234, 16'h2, 1'h0}, '{2'h2, 3'h0, 16'h0, 16'h0, 16'h0531, 16'h1, 1'h0},
      '{2'h3, 3'h1, 16'h0942, 16'h0, 16'h0, 16'h1, 1'h0}, '{2'h2, 3'h0, 16'h0, 16'h0, 16'h0942, 16'h0, 1'h0},
      '{2'h1, 3'h0, 16'h0, 16'h0, 16'h0942, 16'h0, 1'h1}, '{2'h2, 3'h0, 16'h0, 16'h0, 16'h0942, 16'h0, 1'h1}};
   wtq_engine u_dut (.*);
   wtq_mem    u_mem (.*);
   always #12.5 ref_clk = ~ref_clk;
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   always @(posedge ref_clk) begin
      if (++cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   // A poke raises a second request mid-operation, which must be ignored
   task automatic run(input logic [1:0] op, input logic [15:0] b, input logic [2:0] c,
                      input logic [15:0] p, input logic [15:0] i, input bit poke);
      int k;
      op_code = op;
      table_base = b;
      compare_code = c;
      search_pattern = p;
      search_index_in = i;
      op_start = 1'b1;
      @(posedge ref_clk) #1;
      op_start = 1'b0;
      for (k = 0; k < 600 && op_done !== 1'b1; k++) begin
         @(posedge ref_clk) #1;
         op_start = poke && k == 2;
      end
      `CHK(op_done, 1'b1)
      @(posedge ref_clk) #1;
   endtask : run
   initial begin
      u_mem.m[8'h20] = 16'h0006;
      u_mem.m[8'h21] = 16'h0003;
      u_mem.m[8'h22] = 16'h0531;
      u_mem.m[8'h23] = 16'h0942;
      u_mem.m[8'h24] = 16'h0234;
      u_mem.m[8'h40] = 16'h0006;
      u_mem.m[8'h41] = 16'h0004;
      for (int j = 0; j < 4; j++) u_mem.m[8'h42 + j] = 16'h0011 * (j + 1);
      u_mem.m[8'h60] = 16'h0070;
      @(posedge ref_clk) #1;
      `CHK({busy, op_done, mem_rd, mem_wr, data_out_we}, 5'h00)
      repeat (7) @(posedge ref_clk);
      #1 nrst = 1'b1;
      // Row five restarts one above the previous match
      foreach (rows[r]) begin
         run(rows[r].op, rows[r].op == 2'h3 ? 16'h0042 : 16'h0040, rows[r].c, rows[r].p, rows[r].i, 1'b0);
         if (rows[r].op == 2'h3) `CHK(search_index, rows[r].v)
         else `CHK(data_out, rows[r].v)
         `CHK(u_mem.m[8'h21], rows[r].n)
         `CHK(empty_table_flag, rows[r].f)
      end
      `CHK(u_mem.m[8'h20], 16'h0006)
      run(2'h2, 16'h0080, 3'h0, 16'h0000, 16'h0000, 1'b1);
      `CHK(data_out, 16'h0011)
      `CHK(u_mem.m[8'h41], 16'h0003)
      for (int j = 0; j < 3; j++) `CHK(u_mem.m[8'h42 + j], 16'h0011 * (j + 2))
      `CHK(empty_table_flag, 1'b0)
      run(2'h3, 16'h0082, 3'h1, 16'h0044, 16'h0000, 1'b0);
      `CHK(search_index, 16'h0002)
      run(2'h3, 16'h0082, 3'h4, 16'h0044, 16'h0001, 1'b0);
      `CHK(search_index, 16'h0003)
      // Count word above the table limit is taken as a full table
      run(2'h3, 16'h00c0, 3'h1, 16'h0000, 16'h0064, 1'b0);
      `CHK(search_index, 16'h0064)
      close_out();
   end
endmodule : word_table_queue_search_engine_test

// ### bench/wtq_engine_chk.sv
// Purpose: Port checks for the table engine
// Assumes: Memory answers one cycle after each read
// Notes:   Bound to every engine instance
`timescale 1ns/1ps
module wtq_engine_chk (
   // Clock, reset, request, memory address and data, result values
   input wire logic                       ref_clk, nrst, op_start,
   input wire logic [1:0]                 op_code,
   input wire logic [2:0]                 compare_code,
   input wire logic [wtq_pkg::WTQ_AW-1:0] table_base, mem_addr,
   input wire logic [wtq_pkg::WTQ_DW-1:0] search_pattern, search_index_in, mem_wdata,
   input wire logic [wtq_pkg::WTQ_DW-1:0] mem_rdata, data_out, search_index,
   // Strobes and status
   input wire logic                       mem_rd, mem_wr, busy, op_done, data_out_we,
   input wire logic                       search_index_we, empty_table_flag
);
   import wtq_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_no_rd_wr: assert property (!(mem_rd && mem_wr))
      else $error("read and write strobes together");
   a_access_gap: assert property ((mem_rd || mem_wr) |=> !(mem_rd || mem_wr))
      else $error("memory accesses back to back");
   a_first_read: assert property (op_start && !busy && op_code != 2'h0 |=> mem_rd &&
      mem_addr == $past(table_base) + ($past(op_code) == WTQ_OP_SEARCH ? WTQ_CNT_OFS_FIND : WTQ_CNT_OFS_POP))
      else $error("first read not at count word");
   a_done_bound: assert property ($rose(busy) |-> ##[2:450] op_done)
      else $error("operation did not finish");
   a_done_drop: assert property (op_done |=> !busy && !op_done)
      else $error("busy or done held after done");
   a_dout_hold: assert property ($changed(data_out) |-> data_out_we && busy)
      else $error("destination changed without load");
   a_index_hold: assert property ($changed(search_index) |-> search_index_we && !data_out_we)
      else $error("index changed without load");
   a_index_range: assert property (search_index_we |-> search_index <= WTQ_MAX_ENTRIES)
      else $error("index beyond table");
   a_empty_set: assert property ($rose(empty_table_flag) |-> op_done && !data_out_we)
      else $error("empty flag raised outside empty remove");
   a_idle_quiet: assert property (!busy |-> !mem_rd && !mem_wr)
      else $error("memory access while idle");
   c_remove: cover property (data_out_we);
   c_search: cover property (search_index_we);
   c_empty: cover property ($rose(empty_table_flag));
endmodule : wtq_engine_chk
bind wtq_engine wtq_engine_chk u_chk (.*);

// ### bench/wtq_mem.sv
// Purpose: Word data memory seen by the table engine
// Assumes: Byte addresses, 16-bit words, 256 words
// Notes:   Read data valid one cycle after the strobe, scrambled otherwise
`timescale 1ns/1ps
module wtq_mem (
   // Clock
   input  wire logic                       ref_clk,
   // Access
   input  wire logic [wtq_pkg::WTQ_AW-1:0] mem_addr,
   input  wire logic                       mem_rd, mem_wr,
   input  wire logic [wtq_pkg::WTQ_DW-1:0] mem_wdata,
   output logic      [wtq_pkg::WTQ_DW-1:0] mem_rdata
);
   import wtq_pkg::*;
   logic [WTQ_DW-1:0] m [256];
   initial mem_rdata = 16'h5a5a;
   // Toggling outside an answer keeps stale data from passing as valid
   always @(posedge ref_clk) begin
      if (mem_wr) m[mem_addr[8:1]] <= mem_wdata;
      mem_rdata <= mem_rd ? m[mem_addr[8:1]] : ~mem_rdata;
   end
endmodule : wtq_mem

// ### hdl/wtq_cmp.sv
// Purpose: Compares one table entry against the search pattern
// Assumes: Words compare as signed 16-bit integers
// Notes:   Unknown compare codes never match
`timescale 1ns/1ps
module wtq_cmp
   import wtq_pkg::*;
(
   // Operands
   input  wire logic [WTQ_DW-1:0] entry,
   input  wire logic [WTQ_DW-1:0] pattern,
   input  wire logic [2:0]        code,
   // Result
   output logic                   match
);

   always_comb begin
      case (code)
         WTQ_CMP_EQ: match = (entry == pattern);
         WTQ_CMP_NE: match = (entry != pattern);
         WTQ_CMP_LT: match = ($signed(entry) < $signed(pattern));
         WTQ_CMP_GT: match = ($signed(entry) > $signed(pattern));
         default:    match = 1'b0;
      endcase
   end

endmodule : wtq_cmp

// ### hdl/wtq_engine.sv
// Purpose: Removes newest or oldest entry of a word table, or searches it
// Assumes: Memory returns read data in the cycle after mem_rd is seen
// Notes:   One memory access at a time; one entry per compare step
//
// What this block does
// - Stack remove returns newest entry to destination
// - Successful remove decrements entry count by one
// - Remove from empty table sets empty flag
// - Queue remove returns entry zero to destination
// - Queue remove shifts remaining entries down one
// - Search compares entries upward from search index
// - Compare code: 1 eq, 2 ne, 3 lt, 4 gt
// - On match stop, write matching index
// - No match writes entry count to index
// - Entry indices run 0 to 99
// - Table holds at most 100 entries
// - Search base one word above remove base
// - Remove layout: capacity, count, then entries
`timescale 1ns/1ps
module wtq_engine
   import wtq_pkg::*;
(
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   // Operation request
   input  wire logic                   op_start,
   input  wire logic [1:0]             op_code,
   input  wire logic [WTQ_AW-1:0]      table_base,
   input  wire logic [2:0]             compare_code,
   input  wire logic [WTQ_DW-1:0]      search_pattern,
   input  wire logic [WTQ_DW-1:0]      search_index_in,
   // Data memory
   output logic      [WTQ_AW-1:0]      mem_addr,
   output logic                        mem_rd,
   output logic                        mem_wr,
   output logic      [WTQ_DW-1:0]      mem_wdata,
   input  wire logic [WTQ_DW-1:0]      mem_rdata,
   // Results
   output logic                        busy,
   output logic                        op_done,
   output logic      [WTQ_DW-1:0]      data_out,
   output logic                        data_out_we,
   output logic      [WTQ_DW-1:0]      search_index,
   output logic                        search_index_we,
   output logic                        empty_table_flag
);

   typedef struct packed {
      wtq_state_t        st;
      logic [1:0]        op;
      logic [2:0]        cmp;
      logic [WTQ_DW-1:0] pattern;
      logic [WTQ_DW-1:0] cnt;
      logic [WTQ_DW-1:0] idx;
      logic [WTQ_AW-1:0] data_base;
      logic              moving;
      logic [WTQ_AW-1:0] mem_addr;
      logic              mem_rd;
      logic              mem_wr;
      logic [WTQ_DW-1:0] mem_wdata;
      logic              busy;
      logic              done;
      logic [WTQ_DW-1:0] data_out;
      logic              data_out_we;
      logic [WTQ_DW-1:0] search_index;
      logic              search_index_we;
      logic              empty;
   } wtq_regs_t;

   wtq_regs_t         r;
   wtq_regs_t         next_r;
   logic              hit;
   logic [WTQ_DW-1:0] rd_cnt;
   logic [WTQ_DW-1:0] idx_inc;

   wtq_cmp u_cmp (
      .entry   (mem_rdata),
      .pattern (r.pattern),
      .code    (r.cmp),
      .match   (hit)
   );

   // Entry counts above the table limit are clamped
   assign rd_cnt  = (mem_rdata > WTQ_MAX_ENTRIES) ? WTQ_MAX_ENTRIES : mem_rdata;
   assign idx_inc = r.idx + 16'h0001;

   function automatic logic [WTQ_AW-1:0] ent_addr(input logic [WTQ_AW-1:0] base,
                                                  input logic [WTQ_DW-1:0] index);
      ent_addr = base + {index[WTQ_DW-2:0], 1'b0};
   endfunction : ent_addr

   always_comb begin
      next_r                 = r;
      next_r.mem_rd          = 1'b0;
      next_r.mem_wr          = 1'b0;
      next_r.done            = 1'b0;
      next_r.data_out_we     = 1'b0;
      next_r.search_index_we = 1'b0;
      case (r.st)
         WTQ_S_IDLE: begin
            if (op_start && op_code != WTQ_OP_NONE) begin
               next_r.op      = op_code;
               next_r.cmp     = compare_code;
               next_r.pattern = search_pattern;
               next_r.idx     = search_index_in;
               next_r.moving  = 1'b0;
               next_r.busy    = 1'b1;
               next_r.mem_rd  = 1'b1;
               if (op_code == WTQ_OP_SEARCH) begin
                  next_r.mem_addr  = table_base + WTQ_CNT_OFS_FIND;
                  next_r.data_base = table_base + WTQ_DATA_OFS_FIND;
               end else begin
                  next_r.mem_addr  = table_base + WTQ_CNT_OFS_POP;
                  next_r.data_base = table_base + WTQ_DATA_OFS_POP;
               end
               next_r.st = WTQ_S_CNT_RD;
            end
         end
         WTQ_S_CNT_RD: begin
            // While shifting, this state is the idle cycle after each shift write
            if (!r.moving) begin
               next_r.st = WTQ_S_CNT_GET;
            end else if (idx_inc < r.cnt) begin
               next_r.idx      = idx_inc;
               next_r.mem_rd   = 1'b1;
               next_r.mem_addr = ent_addr(r.data_base, idx_inc);
               next_r.st       = WTQ_S_ENT_RD;
            end else begin
               next_r.mem_wr    = 1'b1;
               next_r.mem_wdata = r.cnt - 16'h0001;
               next_r.mem_addr  = r.data_base - 16'h0002;
               next_r.st        = WTQ_S_CNT_WR;
            end
         end
         WTQ_S_CNT_GET: begin
            next_r.cnt = rd_cnt;
            if (r.op == WTQ_OP_SEARCH) begin
               if (r.idx >= rd_cnt) begin
                  next_r.search_index    = rd_cnt;
                  next_r.search_index_we = 1'b1;
                  next_r.done            = 1'b1;
                  next_r.st              = WTQ_S_FIN;
               end else begin
                  next_r.mem_rd   = 1'b1;
                  next_r.mem_addr = ent_addr(r.data_base, r.idx);
                  next_r.st       = WTQ_S_ENT_RD;
               end
            end else if (rd_cnt == 16'h0000) begin
               next_r.empty = 1'b1;
               next_r.done  = 1'b1;
               next_r.st    = WTQ_S_FIN;
            end else begin
               next_r.empty = 1'b0;
               if (r.op == WTQ_OP_POP_NEWEST) begin
                  next_r.idx = rd_cnt - 16'h0001;
               end else begin
                  next_r.idx = 16'h0000;
               end
               next_r.mem_rd   = 1'b1;
               next_r.mem_addr = ent_addr(r.data_base,
                                          (r.op == WTQ_OP_POP_NEWEST) ? rd_cnt - 16'h0001 : 16'h0000);
               next_r.st       = WTQ_S_ENT_RD;
            end
         end
         WTQ_S_ENT_RD: begin
            next_r.st = WTQ_S_ENT_GET;
         end
         WTQ_S_ENT_GET: begin
            if (r.op == WTQ_OP_SEARCH) begin
               if (hit) begin
                  next_r.search_index    = r.idx;
                  next_r.search_index_we = 1'b1;
                  next_r.done            = 1'b1;
                  next_r.st              = WTQ_S_FIN;
               end else if (idx_inc >= r.cnt) begin
                  next_r.search_index    = r.cnt;
                  next_r.search_index_we = 1'b1;
                  next_r.done            = 1'b1;
                  next_r.st              = WTQ_S_FIN;
               end else begin
                  next_r.idx      = idx_inc;
                  next_r.mem_rd   = 1'b1;
                  next_r.mem_addr = ent_addr(r.data_base, idx_inc);
                  next_r.st       = WTQ_S_ENT_RD;
               end
            end else if (r.moving) begin
               // Entry idx moves down into slot idx-1
               next_r.mem_wr    = 1'b1;
               next_r.mem_wdata = mem_rdata;
               next_r.mem_addr  = ent_addr(r.data_base, r.idx - 16'h0001);
               next_r.st        = WTQ_S_MOV_WR;
            end else begin
               next_r.data_out    = mem_rdata;
               next_r.data_out_we = 1'b1;
               if (r.op == WTQ_OP_POP_OLDEST && r.cnt > 16'h0001) begin
                  next_r.moving   = 1'b1;
                  next_r.idx      = 16'h0001;
                  next_r.mem_rd   = 1'b1;
                  next_r.mem_addr = ent_addr(r.data_base, 16'h0001);
                  next_r.st       = WTQ_S_ENT_RD;
               end else begin
                  next_r.mem_wr    = 1'b1;
                  next_r.mem_wdata = r.cnt - 16'h0001;
                  next_r.mem_addr  = r.data_base - 16'h0002;
                  next_r.st        = WTQ_S_CNT_WR;
               end
            end
         end
         WTQ_S_MOV_WR: begin
            // Memory needs a quiet cycle between two accesses
            next_r.st = WTQ_S_CNT_RD;
         end
         WTQ_S_CNT_WR: begin
            next_r.done = 1'b1;
            next_r.st   = WTQ_S_FIN;
         end
         WTQ_S_FIN: begin
            next_r.busy = 1'b0;
            next_r.st   = WTQ_S_IDLE;
         end
         default: begin
            next_r.busy = 1'b0;
            next_r.st   = WTQ_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign mem_addr         = r.mem_addr;
   assign mem_rd           = r.mem_rd;
   assign mem_wr           = r.mem_wr;
   assign mem_wdata        = r.mem_wdata;
   assign busy             = r.busy;
   assign op_done          = r.done;
   assign data_out         = r.data_out;
   assign data_out_we      = r.data_out_we;
   assign search_index     = r.search_index;
   assign search_index_we  = r.search_index_we;
   assign empty_table_flag = r.empty;

endmodule : wtq_engine

// ### hdl/wtq_pkg.sv
// Purpose: Shared constants and types of the word table remove and search engine
// Assumes: 16-bit data words at even byte addresses
// Notes:   Table layout offsets are byte offsets from the operand base address
package wtq_pkg;

   localparam int          WTQ_AW            = 16;
   localparam int          WTQ_DW            = 16;
   localparam logic [15:0] WTQ_MAX_ENTRIES   = 16'h0064;
   // Remove layout: capacity word, entry count word, then entries
   localparam logic [15:0] WTQ_CNT_OFS_POP   = 16'h0002;
   localparam logic [15:0] WTQ_DATA_OFS_POP  = 16'h0004;
   // Search layout starts one word higher: entry count word, then entries
   localparam logic [15:0] WTQ_CNT_OFS_FIND  = 16'h0000;
   localparam logic [15:0] WTQ_DATA_OFS_FIND = 16'h0002;

   // Operation codes from the instruction sequencer
   localparam logic [1:0]  WTQ_OP_NONE       = 2'h0;
   localparam logic [1:0]  WTQ_OP_POP_NEWEST = 2'h1;
   localparam logic [1:0]  WTQ_OP_POP_OLDEST = 2'h2;
   localparam logic [1:0]  WTQ_OP_SEARCH     = 2'h3;

   // Compare codes
   localparam logic [2:0]  WTQ_CMP_EQ        = 3'h1;
   localparam logic [2:0]  WTQ_CMP_NE        = 3'h2;
   localparam logic [2:0]  WTQ_CMP_LT        = 3'h3;
   localparam logic [2:0]  WTQ_CMP_GT        = 3'h4;

   typedef enum logic [2:0] {
      WTQ_S_IDLE    = 3'h0,
      WTQ_S_CNT_RD  = 3'h1,
      WTQ_S_CNT_GET = 3'h3,
      WTQ_S_ENT_RD  = 3'h2,
      WTQ_S_ENT_GET = 3'h6,
      WTQ_S_MOV_WR  = 3'h7,
      WTQ_S_CNT_WR  = 3'h5,
      WTQ_S_FIN     = 3'h4
   } wtq_state_t;

endpackage : wtq_pkg
